// File: hdl/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic do_push;
   logic do_pop;

   assign in_ready = !((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
   assign out_valid = (wr_ptr_r != rd_ptr_r);
   assign out_data = mem[rd_ptr_r[AW-1:0]];
   assign do_push = in_valid && in_ready;
   assign do_pop = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (do_push)
      begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         if (do_push)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule : byte_fifo
`default_nettype wire

// File: hdl/flash_ctrl_pkg.sv
`default_nettype none
package flash_ctrl_pkg;
   localparam int CLK_MHZ = 10;
   // internal cycle durations, in microseconds
   localparam int STATUS_WRITE_TIME_US = 10000;
   localparam int PROGRAM_CYCLE_TIME_US = 1500;
   localparam int SECTOR_ERASE_TIME_US = 300000;
   localparam int BULK_ERASE_TIME_US = 10000000;

   localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
   localparam logic [7:0] READ_STATUS_CMD = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
   localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
   localparam logic [7:0] BULK_ERASE_CMD = 8'hC7;
   localparam logic [7:0] DEEP_SLEEP_CMD = 8'hB9;
   localparam logic [7:0] WAKE_AND_ID_CMD = 8'hAB;

   localparam int ST_WIP = 0;
   localparam int ST_WEL = 1;
   localparam int ST_BP_LO = 2;
   localparam int ST_SRP = 7;
   localparam logic [7:0] NV_STATUS_INIT = 8'h00;

   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] HDR_NONE = 3'h0;
   localparam logic [2:0] HDR_OPCODE = 3'h1;
   localparam logic [2:0] HDR_STATUS = 3'h2;
   localparam logic [2:0] HDR_ADDR = 3'h4;
   localparam logic [2:0] HDR_DATA = 3'h5;

   localparam logic [2:0] BP_NONE = 3'h0;
   localparam logic [2:0] BP_HALF = 3'h6;
   localparam logic [2:0] BP_ALL = 3'h7;
   localparam logic [20:0] ARRAY_BYTES = 21'h100000;
   localparam logic [20:0] HALF_BYTES = 21'h080000;
   localparam logic [20:0] PROT_UNIT = 21'h001000;

   localparam int FIFO_DEPTH = 8;

   typedef enum logic [1:0] {PWR_STANDBY, PWR_ACTIVE, PWR_DEEP} power_mode_t;
   typedef enum logic [1:0] {ARR_PROGRAM, ARR_SECTOR_ERASE, ARR_BULK_ERASE, ARR_ABORT} arr_op_t;
   typedef struct packed {
      arr_op_t op;
      logic [23:0] addr;
   } arr_cmd_t;
   typedef struct packed {
      logic [7:0] offset;
      logic [7:0] data;
   } page_byte_t;
endpackage : flash_ctrl_pkg
`default_nettype wire

// File: hdl/serial_flash_write_protect_ctrl.sv
// Behaviour
// - works in spi mode 0 and 3
// - sample input on rise, drive output on fall
// - program up to 256 bytes within one page
// - erase sets bytes to ones, starts cycle
// - modifying commands need write enable latch set
// - latch cleared at reset and after writes
// - status shows latch and busy bit
// - writes need clock count multiple of eight
// - active while selected or internally busy
// - deep sleep until wake command
// - deep sleep ignores everything but wake
// - block protect bits are non-volatile; here sys_rst reloads them from the constant NV_STATUS_INIT
// - lock bit plus pin low freezes status
// - bottom boot protect ranges from low address
// - top boot protect ranges from top address
// - deselect must fall on a byte boundary
// - sector erase needs exactly 24 address bits
// - busy cycle ignores array access commands
// - all fields shifted most significant bit first
`timescale 1ns/1ps
`default_nettype none
module serial_flash_write_protect_ctrl
   import flash_ctrl_pkg::*;
#(
   parameter bit TOP_BOOT = 1'b0,
   parameter int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_US * CLK_MHZ,
   parameter int PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_US * CLK_MHZ,
   parameter int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ,
   parameter int BULK_ERASE_CYCLES = BULK_ERASE_TIME_US * CLK_MHZ
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic spi_clk_pin,
   input wire logic chip_sel_n,
   input wire logic serial_in_pin,
   input wire logic write_protect_n,
   output logic serial_out,
   output logic serial_out_en,
   output logic page_valid,
   input wire logic page_ready,
   output page_byte_t page_byte,
   output logic arr_cmd_valid,
   output arr_cmd_t arr_cmd,
   output power_mode_t power_mode,
   output logic [7:0] nv_status
);
   logic [1:0] sck_sync_r;
   logic [1:0] cs_sync_r;
   logic [1:0] si_sync_r;
   logic [1:0] wp_sync_r;
   logic sck_d_r;
   logic cs_d_r;
   logic [2:0] bit_cnt_r;
   logic [2:0] hdr_cnt_r;
   logic [6:0] shift_r;
   logic [7:0] opcode_r;
   logic [23:0] addr_r;
   logic [7:0] status_in_r;
   logic pushed_r;
   logic overrun_r;
   logic [2:0] out_cnt_r;
   logic [7:0] out_snap_r;
   logic write_enable_latch_r;
   logic write_in_progress_r;
   logic [31:0] busy_cnt_r;
   logic deep_r;
   logic [2:0] block_protect_r;
   logic status_lock_bit_r;
   logic serial_out_r;
   logic serial_out_en_r;
   logic page_valid_r;
   page_byte_t page_byte_r;
   logic arr_cmd_valid_r;
   arr_cmd_t arr_cmd_r;
   power_mode_t power_mode_r;

   logic selected;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic byte_done;
   logic [7:0] rx_byte;
   logic [7:0] status_byte;
   logic hardware_protected_mode;
   logic boundary;
   logic idle_ok;
   logic rd_status;
   logic push;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   page_byte_t fifo_out_data;
   page_byte_t push_byte;
   logic do_write_enable_cmd;
   logic do_write_disable_cmd;
   logic do_status_write_cmd;
   logic do_prog;
   logic do_sector;
   logic do_bulk;
   logic do_sleep;
   logic do_abort;
   logic do_wake;

   // bottom boot grows up from zero, top boot grows down from the end
   function automatic logic prot_hit(input logic [19:0] a, input logic [2:0] bp);
      logic [20:0] size;
      size = '0;
      case (bp)
         BP_NONE: size = '0;
         BP_HALF: size = HALF_BYTES;
         BP_ALL: size = ARRAY_BYTES;
         default: size = 21'(PROT_UNIT << (bp - 3'h1));
      endcase
      if (TOP_BOOT)
      begin
         prot_hit = ({1'b0, a} >= (ARRAY_BYTES - size));
      end
      else
      begin
         prot_hit = ({1'b0, a} < size);
      end
   endfunction : prot_hit

   // the spi clock is only sampled, so it must stay well below clk/4
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sck_sync_r <= 2'h0;
         cs_sync_r <= 2'h3;
         si_sync_r <= 2'h0;
         wp_sync_r <= 2'h3;
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end
      else
      begin
         sck_sync_r <= {sck_sync_r[0], spi_clk_pin};
         cs_sync_r <= {cs_sync_r[0], chip_sel_n};
         si_sync_r <= {si_sync_r[0], serial_in_pin};
         wp_sync_r <= {wp_sync_r[0], write_protect_n};
         sck_d_r <= sck_sync_r[1];
         cs_d_r <= cs_sync_r[1];
      end
   end

   // edges are taken only while selected, so the idle level never matters
   assign selected = !cs_sync_r[1];
   assign sck_rise = selected && sck_sync_r[1] && !sck_d_r;
   assign sck_fall = selected && !sck_sync_r[1] && sck_d_r;
   assign cs_fall = !cs_sync_r[1] && cs_d_r;
   assign cs_rise = cs_sync_r[1] && !cs_d_r;
   assign byte_done = sck_rise && (bit_cnt_r == BIT_LAST);
   assign rx_byte = {shift_r, si_sync_r[1]};
   assign hardware_protected_mode = status_lock_bit_r && !wp_sync_r[1];
   assign status_byte = {status_lock_bit_r, 2'b00, block_protect_r,
                         write_enable_latch_r, write_in_progress_r};
   assign boundary = (bit_cnt_r == 3'h0);
   assign idle_ok = !write_in_progress_r && !deep_r;
   assign rd_status = (opcode_r == READ_STATUS_CMD) && (hdr_cnt_r != HDR_NONE) && !deep_r;

   always_ff @(posedge clk)
   begin
      if (sys_rst || cs_fall)
      begin
         bit_cnt_r <= '0;
         hdr_cnt_r <= HDR_NONE;
         shift_r <= '0;
         opcode_r <= '0;
      end
      else if (sck_rise)
      begin
         shift_r <= rx_byte[6:0];
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (byte_done && (hdr_cnt_r != HDR_DATA))
         begin
            hdr_cnt_r <= hdr_cnt_r + 3'h1;
         end
         if (byte_done && (hdr_cnt_r == HDR_NONE))
         begin
            opcode_r <= rx_byte;
         end
      end
   end

   // page offset wraps inside the page, so a long burst never leaves it
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         addr_r <= '0;
         status_in_r <= '0;
      end
      else if (byte_done)
      begin
         if ((hdr_cnt_r != HDR_NONE) && (hdr_cnt_r < HDR_ADDR))
         begin
            addr_r <= {addr_r[15:0], rx_byte};
         end
         else if (hdr_cnt_r >= HDR_ADDR)
         begin
            addr_r[7:0] <= addr_r[7:0] + 8'h01;
         end
         if (hdr_cnt_r == HDR_OPCODE)
         begin
            status_in_r <= rx_byte;
         end
      end
   end

   // bytes stream to the array page buffer as they arrive; commit comes at deselect
   assign push = byte_done && (hdr_cnt_r >= HDR_ADDR) && (opcode_r == PAGE_PROGRAM_CMD)
                 && write_enable_latch_r && idle_ok
                 && !prot_hit(addr_r[19:0], block_protect_r);
   assign push_byte = '{offset: addr_r[7:0], data: rx_byte};

   // a full fifo cannot stall the master, so a lost byte voids the whole page
   always_ff @(posedge clk)
   begin
      if (sys_rst || cs_fall)
      begin
         pushed_r <= 1'b0;
         overrun_r <= 1'b0;
      end
      else if (push)
      begin
         pushed_r <= 1'b1;
         if (!fifo_in_ready)
         begin
            overrun_r <= 1'b1;
         end
      end
   end

   assign do_write_enable_cmd = cs_rise && boundary && idle_ok && (opcode_r == WRITE_ENABLE_CMD)
                    && (hdr_cnt_r == HDR_OPCODE);
   assign do_write_disable_cmd = cs_rise && boundary && idle_ok && (opcode_r == WRITE_DISABLE_CMD)
                    && (hdr_cnt_r == HDR_OPCODE);
   assign do_status_write_cmd = cs_rise && boundary && idle_ok && (opcode_r == STATUS_WRITE_CMD)
                    && (hdr_cnt_r == HDR_STATUS) && write_enable_latch_r
                    && !hardware_protected_mode;
   assign do_prog = cs_rise && boundary && (opcode_r == PAGE_PROGRAM_CMD)
                    && (hdr_cnt_r == HDR_DATA) && pushed_r && !overrun_r;
   assign do_sector = cs_rise && boundary && idle_ok && (opcode_r == SECTOR_ERASE_CMD)
                      && (hdr_cnt_r == HDR_ADDR) && write_enable_latch_r
                      && !prot_hit(addr_r[19:0], block_protect_r);
   assign do_bulk = cs_rise && boundary && idle_ok && (opcode_r == BULK_ERASE_CMD)
                    && (hdr_cnt_r == HDR_OPCODE) && write_enable_latch_r
                    && (block_protect_r == BP_NONE);
   assign do_sleep = cs_rise && boundary && idle_ok && (opcode_r == DEEP_SLEEP_CMD)
                     && (hdr_cnt_r == HDR_OPCODE);
   assign do_abort = cs_rise && pushed_r && !do_prog;
   assign do_wake = byte_done && (hdr_cnt_r == HDR_NONE) && deep_r
                    && (rx_byte == WAKE_AND_ID_CMD);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         write_enable_latch_r <= 1'b0;
      end
      else if (do_write_enable_cmd)
      begin
         write_enable_latch_r <= 1'b1;
      end
      else if (do_write_disable_cmd || do_status_write_cmd || do_prog || do_sector || do_bulk)
      begin
         write_enable_latch_r <= 1'b0;
      end
   end

   // reset loads the constant NV_STATUS_INIT; nv_status lets the backing store keep it
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         block_protect_r <= NV_STATUS_INIT[ST_BP_LO +: 3];
         status_lock_bit_r <= NV_STATUS_INIT[ST_SRP];
      end
      else if (do_status_write_cmd)
      begin
         block_protect_r <= status_in_r[ST_BP_LO +: 3];
         status_lock_bit_r <= status_in_r[ST_SRP];
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         write_in_progress_r <= 1'b0;
         busy_cnt_r <= '0;
      end
      else if (do_status_write_cmd || do_prog || do_sector || do_bulk)
      begin
         write_in_progress_r <= 1'b1;
         if (do_status_write_cmd)
         begin
            busy_cnt_r <= 32'(STATUS_WRITE_CYCLES);
         end
         else if (do_prog)
         begin
            busy_cnt_r <= 32'(PROGRAM_CYCLES);
         end
         else if (do_sector)
         begin
            busy_cnt_r <= 32'(SECTOR_ERASE_CYCLES);
         end
         else
         begin
            busy_cnt_r <= 32'(BULK_ERASE_CYCLES);
         end
      end
      else if (write_in_progress_r)
      begin
         busy_cnt_r <= busy_cnt_r - 32'h1;
         if (busy_cnt_r == 32'h1)
         begin
            write_in_progress_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         deep_r <= 1'b0;
      end
      else if (do_sleep)
      begin
         deep_r <= 1'b1;
      end
      else if (do_wake)
      begin
         deep_r <= 1'b0;
      end
   end

   // status repeats byte after byte; a snapshot per byte keeps each byte coherent
   always_ff @(posedge clk)
   begin
      if (sys_rst || cs_fall)
      begin
         out_cnt_r <= '0;
         out_snap_r <= '0;
         serial_out_r <= 1'b0;
      end
      else if (sck_fall && rd_status)
      begin
         out_cnt_r <= out_cnt_r + 3'h1;
         if (out_cnt_r == 3'h0)
         begin
            out_snap_r <= status_byte;
            serial_out_r <= status_byte[BIT_LAST];
         end
         else
         begin
            serial_out_r <= out_snap_r[BIT_LAST - out_cnt_r];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         serial_out_en_r <= 1'b0;
         power_mode_r <= PWR_STANDBY;
      end
      else
      begin
         serial_out_en_r <= selected && rd_status;
         if (deep_r)
         begin
            power_mode_r <= PWR_DEEP;
         end
         else if (selected || write_in_progress_r)
         begin
            power_mode_r <= PWR_ACTIVE;
         end
         else
         begin
            power_mode_r <= PWR_STANDBY;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         arr_cmd_valid_r <= 1'b0;
         arr_cmd_r <= '{op: ARR_ABORT, addr: '0};
      end
      else
      begin
         arr_cmd_valid_r <= do_prog || do_sector || do_bulk || do_abort;
         if (do_prog)
         begin
            arr_cmd_r <= '{op: ARR_PROGRAM, addr: {addr_r[23:8], 8'h00}};
         end
         else if (do_sector)
         begin
            arr_cmd_r <= '{op: ARR_SECTOR_ERASE, addr: addr_r};
         end
         else if (do_bulk)
         begin
            arr_cmd_r <= '{op: ARR_BULK_ERASE, addr: '0};
         end
         else if (do_abort)
         begin
            arr_cmd_r <= '{op: ARR_ABORT, addr: addr_r};
         end
      end
   end

   byte_fifo #(
      .WIDTH($bits(page_byte_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_page_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_byte),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   assign fifo_out_ready = !page_valid_r || page_ready;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         page_valid_r <= 1'b0;
         page_byte_r <= '0;
      end
      else if (fifo_out_ready)
      begin
         page_valid_r <= fifo_out_valid;
         page_byte_r <= fifo_out_data;
      end
   end

   assign serial_out = serial_out_r;
   assign serial_out_en = serial_out_en_r;
   assign page_valid = page_valid_r;
   assign page_byte = page_byte_r;
   assign arr_cmd_valid = arr_cmd_valid_r;
   assign arr_cmd = arr_cmd_r;
   assign power_mode = power_mode_r;
   assign nv_status = {status_lock_bit_r, 2'b00, block_protect_r, 2'b00};
endmodule : serial_flash_write_protect_ctrl
`default_nettype wire

// File: tb/flash_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_sva
   import flash_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic spi_clk_pin,
   input wire logic chip_sel_n,
   input wire logic serial_in_pin,
   input wire logic write_protect_n,
   input wire logic serial_out,
   input wire logic serial_out_en,
   input wire logic page_valid,
   input wire logic page_ready,
   input wire page_byte_t page_byte,
   input wire logic arr_cmd_valid,
   input wire arr_cmd_t arr_cmd,
   input wire power_mode_t power_mode,
   input wire logic [7:0] nv_status
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   property p_cmd_pulse;
      arr_cmd_valid |=> !arr_cmd_valid;
   endproperty
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
   property p_cmd_deselected;
      arr_cmd_valid |-> chip_sel_n && $past(chip_sel_n, 2);
   endproperty
   a_cmd_deselected: assert property (p_cmd_deselected) else $error("command while selected");
   property p_active_sel;
      !chip_sel_n [*6] |-> power_mode != PWR_STANDBY;
   endproperty
   a_active_sel: assert property (p_active_sel) else $error("standby while selected");
   property p_deep_quiet;
      arr_cmd_valid |-> $past(power_mode) != PWR_DEEP;
   endproperty
   a_deep_quiet: assert property (p_deep_quiet) else $error("command in deep sleep");
   property p_page_hold;
      page_valid && !page_ready |=> page_valid && $stable(page_byte);
   endproperty
   a_page_hold: assert property (p_page_hold) else $error("page byte dropped");
   property p_out_idle;
      chip_sel_n [*6] |-> !serial_out_en;
   endproperty
   a_out_idle: assert property (p_out_idle) else $error("output driven deselected");
   property p_hw_lock;
      (nv_status[7] && !write_protect_n) [*6] |=> $stable(nv_status);
   endproperty
   a_hw_lock: assert property (p_hw_lock) else $error("status changed while locked");
   property p_all_prot;
      arr_cmd_valid && arr_cmd.op != ARR_ABORT |-> nv_status[4:2] != BP_ALL;
   endproperty
   a_all_prot: assert property (p_all_prot) else $error("command with array protected");
   property p_bulk_prot;
      arr_cmd_valid && arr_cmd.op == ARR_BULK_ERASE |-> nv_status[4:2] == BP_NONE;
   endproperty
   a_bulk_prot: assert property (p_bulk_prot) else $error("bulk erase while protected");

   c_program: cover property (arr_cmd_valid && arr_cmd.op == ARR_PROGRAM);
   c_stall: cover property (page_valid && !page_ready);
   c_deep: cover property (power_mode == PWR_DEEP);
   c_abort: cover property (arr_cmd_valid && arr_cmd.op == ARR_ABORT);
endmodule : flash_ctrl_sva
`default_nettype wire

// File: tb/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire logic clk,
   input wire logic serial_out,
   output logic spi_clk,
   output logic cs_n,
   output logic mosi
);
   logic mode3 = 1'b0;

   initial
   begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // output is read just before the next fall, where it is sure to have settled
   task automatic xfer(input logic [127:0] data, input int nbits, output logic [7:0] rd);
      @(posedge clk) #1;
      // settle the idle level first, so a mode change never looks like an edge while selected
      spi_clk = mode3;
      #400 cs_n = 1'b0;
      rd = 8'h00;
      for (int i = nbits - 1; i >= 0; i--)
      begin
         #400 rd = {rd[6:0], serial_out};
         spi_clk = 1'b0;
         mosi = data[i];
         #400 spi_clk = 1'b1;
      end
      #400 rd = {rd[6:0], serial_out};
      spi_clk = mode3;
      #400 cs_n = 1'b1;
      mosi = ~mosi;
      #1600;
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import flash_ctrl_pkg::*;
;
   logic clk, sys_rst, spi_clk_pin, chip_sel_n, serial_in_pin, write_protect_n;
   logic serial_out, serial_out_en, page_valid, page_ready, arr_cmd_valid, miso;
   page_byte_t page_byte;
   arr_cmd_t arr_cmd;
   power_mode_t power_mode;
   logic [7:0] nv_status, rd;
   logic [23:0] lim;
   int n_fail = 0;
   int num_checks = 0;
   arr_cmd_t cmds[$];
   page_byte_t pages[$];

   serial_flash_write_protect_ctrl #(.TOP_BOOT(1'b0), .STATUS_WRITE_CYCLES(600),
      .PROGRAM_CYCLES(600), .SECTOR_ERASE_CYCLES(600), .BULK_ERASE_CYCLES(600))
   u_serial_flash_write_protect_ctrl (.clk(clk), .sys_rst(sys_rst),
      .spi_clk_pin(spi_clk_pin), .chip_sel_n(chip_sel_n), .serial_in_pin(serial_in_pin),
      .write_protect_n(write_protect_n), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .page_valid(page_valid), .page_ready(page_ready),
      .page_byte(page_byte), .arr_cmd_valid(arr_cmd_valid), .arr_cmd(arr_cmd),
      .power_mode(power_mode), .nv_status(nv_status));

   // a released output reads inverted, so a late or missing enable corrupts the status
   assign miso = serial_out_en ? serial_out : !serial_out;

   spi_host_model u_spi_host_model (.clk(clk), .serial_out(miso),
      .spi_clk(spi_clk_pin), .cs_n(chip_sel_n), .mosi(serial_in_pin));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (arr_cmd_valid === 1'b1)
         cmds.push_back(arr_cmd);
      if (page_valid === 1'b1 && page_ready === 1'b1)
         pages.push_back(page_byte);
   end

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic xf(input logic [127:0] d, input int n);
      u_spi_host_model.xfer(d, n, rd);
   endtask : xf

   task automatic op(input logic [7:0] c);
      xf(c, 8);
   endtask : op

   task automatic st(input logic [7:0] e);
      xf(16'h0500, 16);
      chk("status", rd, e);
   endtask : st

   task automatic idle();
      for (int k = 0; k < 40; k++)
      begin
         xf(16'h0500, 16);
         if (rd[0] === 1'b0)
            break;
      end
      chk("busy", rd[0], 1'b0);
   endtask : idle

   task automatic cmd_chk(input int n, input arr_cmd_t e);
      chk("cmd count", cmds.size(), n);
      if (n > 0 && cmds.size() > 0)
         chk("cmd", cmds[0], e);
      cmds.delete();
   endtask : cmd_chk

   task automatic test_done();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   initial
   begin
      #6_000_000;
      n_fail++;
      test_done();
   end

   initial
   begin
      sys_rst = 1'b1;
      write_protect_n = 1'b1;
      page_ready = 1'b1;
      repeat (16) @(posedge clk);
      #1 sys_rst = 1'b0;
      repeat (4) @(posedge clk);
      st(8'h00);
      u_spi_host_model.mode3 = 1'b1;
      op(WRITE_ENABLE_CMD);
      st(8'h02);
      u_spi_host_model.mode3 = 1'b0;
      op(WRITE_DISABLE_CMD);
      st(8'h00);
      xf({PAGE_PROGRAM_CMD, 24'h000300, 8'hAA}, 40);
      cmd_chk(0, '0);
      chk("pages", pages.size(), 0);
      op(WRITE_ENABLE_CMD);
      page_ready = 1'b0;
      xf({PAGE_PROGRAM_CMD, 24'h000104, 24'h112233}, 56);
      cmd_chk(1, {ARR_PROGRAM, 24'h000100});
      chk("stall", page_valid, 1'b1);
      chk("mode", power_mode, PWR_ACTIVE);
      @(posedge clk) #1 page_ready = 1'b1;
      st(8'h01);
      chk("pages", pages.size(), 3);
      for (int i = 0; i < 3; i++)
         chk("page", pages[i], {8'(4 + i), 8'(8'h11 * (i + 1))});
      idle();
      // ten bytes against a stalled sink: nine fit, the tenth voids the page
      pages.delete();
      page_ready = 1'b0;
      op(WRITE_ENABLE_CMD);
      xf({PAGE_PROGRAM_CMD, 24'h000200, 80'h0102030405060708090A}, 112);
      chk("abort", cmds.size(), 1);
      chk("op", cmds[0].op, ARR_ABORT);
      cmds.delete();
      page_ready = 1'b1;
      #2000 chk("drain", pages.size(), 9);
      chk("page", pages[0], 16'h0001);
      op(WRITE_ENABLE_CMD);
      xf({PAGE_PROGRAM_CMD, 16'h0002, 3'h1}, 27);
      cmd_chk(0, '0);
      xf({SECTOR_ERASE_CMD, 16'h0100}, 24);
      xf({SECTOR_ERASE_CMD, 32'h00012345}, 40);
      cmd_chk(0, '0);
      st(8'h02);
      for (int c = 1; c < 8; c++)
      begin
         lim = (c == 7) ? 24'h000000 : (c == 6) ? 24'h080000 : 24'h000800 << c;
         op(WRITE_ENABLE_CMD);
         xf({STATUS_WRITE_CMD, 3'h0, 3'(c), 2'h0}, 16);
         idle();
         st({3'h0, 3'(c), 2'h0});
         op(WRITE_ENABLE_CMD);
         xf({SECTOR_ERASE_CMD, lim - 24'h000001}, 32);
         cmd_chk(0, '0);
         if (c < 7)
         begin
            op(WRITE_ENABLE_CMD);
            xf({SECTOR_ERASE_CMD, lim}, 32);
            cmd_chk(1, {ARR_SECTOR_ERASE, lim});
            op(WRITE_ENABLE_CMD);
            st({3'h0, 3'(c), 2'h1});
            idle();
         end
      end
      op(WRITE_ENABLE_CMD);
      op(BULK_ERASE_CMD);
      cmd_chk(0, '0);
      op(WRITE_ENABLE_CMD);
      xf(16'h0180, 16);
      idle();
      write_protect_n = 1'b0;
      op(WRITE_ENABLE_CMD);
      xf(16'h011C, 16);
      repeat (8) @(posedge clk);
      #1 chk("nv", nv_status, 8'h80);
      write_protect_n = 1'b1;
      op(WRITE_ENABLE_CMD);
      xf(16'h0100, 16);
      idle();
      chk("nv", nv_status, 8'h00);
      op(WRITE_ENABLE_CMD);
      op(BULK_ERASE_CMD);
      chk("bulk", cmds.size(), 1);
      chk("op", cmds[0].op, ARR_BULK_ERASE);
      cmds.delete();
      idle();
      op(DEEP_SLEEP_CMD);
      chk("mode", power_mode, PWR_DEEP);
      op(WRITE_ENABLE_CMD);
      op(BULK_ERASE_CMD);
      cmd_chk(0, '0);
      op(WAKE_AND_ID_CMD);
      st(8'h00);
      chk("mode", power_mode, PWR_STANDBY);
      test_done();
   end
endmodule : tb

bind serial_flash_write_protect_ctrl flash_ctrl_sva u_flash_ctrl_sva (.clk(clk),
   .sys_rst(sys_rst), .spi_clk_pin(spi_clk_pin), .chip_sel_n(chip_sel_n),
   .serial_in_pin(serial_in_pin), .write_protect_n(write_protect_n),
   .serial_out(serial_out), .serial_out_en(serial_out_en), .page_valid(page_valid),
   .page_ready(page_ready), .page_byte(page_byte), .arr_cmd_valid(arr_cmd_valid),
   .arr_cmd(arr_cmd), .power_mode(power_mode), .nv_status(nv_status));
`default_nettype wire
